// ==== mdp_pkg.sv ====
package mdp_pkg;
   // Register indices (word indices, not byte offsets: byte address = 4*index).
   localparam logic [11:0] IDX_MAINS_FREQ = 12'h022;
   localparam logic [11:0] IDX_CONTRAST = 12'h023;
   localparam logic [11:0] IDX_OP_LIGHT = 12'h024;
   localparam logic [11:0] IDX_SCREEN_PROF = 12'h025;
   localparam logic [11:0] IDX_ROT_PROF = 12'h026;
   localparam logic [11:0] IDX_ROT_TIME = 12'h027;
   localparam logic [11:0] IDX_MINMAX_CLR = 12'h1fa;
   localparam logic [11:0] IDX_ENERGY_CLR = 12'h1fb;
   localparam logic [11:0] IDX_IDLE_INTERVAL = 12'h2ea;
   localparam logic [11:0] IDX_STBY_LIGHT = 12'h2eb;
   localparam logic [11:0] IDX_STATUS = 12'h300;
   localparam logic [11:0] IDX_CONTROL = 12'h301;
   // Status and control field positions.
   localparam int ST_FREQ_ERR = 0;
   localparam int ST_AUTO_ROT = 1;
   localparam int ST_STANDBY = 2;
   localparam int ST_ROT_DIR_LO = 3;
   localparam int ST_ERR_CODE_LO = 16;
   localparam int CT_ERR_ACK = 0;
   // Reset values and limits.
   localparam logic [15:0] RST_MAINS_FREQ = 16'h0000;
   localparam logic [15:0] RST_CONTRAST = 16'h0005;
   localparam logic [15:0] RST_OP_LIGHT = 16'h0006;
   localparam logic [15:0] RST_PROFILE = 16'h0000;
   localparam logic [15:0] RST_ROT_TIME = 16'h0000;
   localparam logic [15:0] RST_IDLE_INTERVAL = 16'h0384;
   localparam logic [15:0] RST_STBY_LIGHT = 16'h0000;
   localparam logic [15:0] CLEAR_CMD = 16'h0001;
   localparam logic [15:0] FREQ_MIN = 16'h002d;
   localparam logic [15:0] FREQ_MAX = 16'h0041;
   localparam logic [15:0] LEVEL_MAX = 16'h0009;
   localparam logic [15:0] PROF_MAX = 16'h0003;
   localparam logic [15:0] ROT_TIME_MAX = 16'h003c;
   localparam logic [15:0] IDLE_MIN = 16'h003c;
   localparam logic [15:0] IDLE_MAX = 16'h270f;
   localparam logic [15:0] FREQ_ERR_CODE = 16'h01f4;
   localparam logic [3:0] LIGHT_MIN = 4'h0;
   localparam logic [3:0] LIGHT_MAX = 4'h9;
   // Timing.
   localparam longint CLK_HZ = 125000000;
   localparam int ERR_HOLD_S = 5;
   localparam int MANUAL_TIMEOUT_S = 60;
   localparam int SCREEN_REFRESH_S = 1;
   localparam int FLASH_HALF_MS = 500;
   typedef enum logic [1:0] {ROT_NONE, ROT_RIGHT, ROT_LEFT} mdp_rot_t;
endpackage

// ==== mdp_tick_if.sv ====
interface mdp_tick_if;
   logic secTick;
   logic flashTick;
   modport source (output secTick, output flashTick);
   modport sink (input secTick, input flashTick);
endinterface

// ==== mdp_tick_gen.sv ====
module mdp_tick_gen #(
   parameter longint SEC_CYCLES = mdp_pkg::CLK_HZ,
   parameter longint FLASH_CYCLES = mdp_pkg::CLK_HZ / 2
)(
   input wire logic clk,
   input wire logic sys_rst,
   mdp_tick_if.source ticks
);
   import mdp_pkg::*;
   logic [31:0] secCnt;
   logic [31:0] flashCnt;
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         secCnt <= 32'h0;
      else if (secCnt >= 32'(SEC_CYCLES - 1))
         secCnt <= 32'h0;
      else
         secCnt <= secCnt + 32'h1;
   end
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         flashCnt <= 32'h0;
      else if (flashCnt >= 32'(FLASH_CYCLES - 1))
         flashCnt <= 32'h0;
      else
         flashCnt <= flashCnt + 32'h1;
   end
   assign ticks.secTick = (secCnt >= 32'(SEC_CYCLES - 1));
   assign ticks.flashTick = (flashCnt >= 32'(FLASH_CYCLES - 1));
endmodule

// ==== mdp_param_bank.sv ====
// Contract
// - Writing 1 to min/max clear pulses a clear of all min/max values.
// - Auto frequency detection runs only while phase-one voltage exceeds 10 V.
// - Auto mode with voltage absent and no frequency raises error 500.
// - During the error the last measured frequency stays in use.
// - The error clears itself about 5 s after frequency returns.
// - No frequency error while a fixed frequency is set.
// - Mains frequency accepts 0 (automatic) or 45 to 65 Hz.
// - Writing 1 to energy clear resets all three energy meters together.
// - Harmonics up to order 40 on a 45 to 65 Hz fundamental.
// - Distortion ratio is root of summed harmonics over fundamental.
// - Values recalculated every 10/12 periods, screens refreshed each second.
// - Auto rotation only with a rotation time above zero.
// - Buttons step screens; 60 s without press returns to rotation.
// - Rotation time 0 to 60 s for all profiles; 0 disables rotation.
// - Rotation profile selector takes 0 to 3; 3 is user-defined.
// - Screen profile 0 to 3; first screen shown after power returns.
// - Clockwise shows right-hand, anticlockwise left-hand, else stationary.
// - Contrast 0 to 9, default 5.
// - Operating backlight level 0 to 9, default 6, on press and restart.
// - After idle interval 60 to 9999 s, default 900, standby level applies.
// - Buttons one to three restore operating level and restart idle time.
// - Identify request flashes backlight between maximum and minimum.
//
// Implementation choice: register access over APB.
module mdp_param_bank #(
   parameter longint SEC_CYCLES = mdp_pkg::CLK_HZ,
   parameter int SCREEN_COUNT_W = 4
)(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [13:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [2:0] buttonPress,
   input wire logic voltagePresent,
   input wire logic freqValid,
   input wire logic [15:0] measuredFreq,
   input wire logic phaseSeqValid,
   input wire logic phaseSeqClockwise,
   input wire logic identifyRequest,
   input wire logic calcStrobe,
   output logic minmaxClear,
   output logic energyClear,
   output logic freqAutoEnable,
   output logic [15:0] effectiveFreq,
   output logic freqError,
   output logic [15:0] errorCode,
   output logic [5:0] harmonicMaxOrder,
   output logic calcEnable,
   output logic screenRefresh,
   output logic autoRotate,
   output logic [1:0] activeProfile,
   output logic [SCREEN_COUNT_W-1:0] screenIndex,
   output logic [1:0] rotationIndicator,
   output logic [3:0] contrastLevel,
   output logic [3:0] backlightLevel
);
   import mdp_pkg::*;

   localparam logic [5:0] HARMONIC_ORDER = 6'h28;
   localparam logic [15:0] ERR_HOLD_SEC = 16'(ERR_HOLD_S);
   localparam logic [15:0] MANUAL_SEC = 16'(MANUAL_TIMEOUT_S);

   mdp_tick_if ticks();
   mdp_tick_gen #(.SEC_CYCLES(SEC_CYCLES),
      .FLASH_CYCLES(SEC_CYCLES * FLASH_HALF_MS / 1000)) uTicks (
      .clk(clk),
      .sys_rst(sys_rst),
      .ticks(ticks)
   );

   logic [15:0] mainsFreqSel;
   logic [15:0] contrast;
   logic [15:0] opLight;
   logic [15:0] screenProfile;
   logic [15:0] rotProfile;
   logic [15:0] rotTime;
   logic [15:0] idleInterval;
   logic [15:0] stbyLight;
   logic [15:0] lastFreq;
   logic [15:0] errHoldCnt;
   logic [15:0] idleCnt;
   logic [15:0] manualCnt;
   logic [15:0] rotCnt;
   logic standby;
   logic manualMode;
   logic flashPhase;
   logic anyPress;
   logic stepPress;
   logic errAck;
   logic [11:0] regIdx;
   logic wrStrobe;
   logic [15:0] wdata;
   logic mapped;

   assign regIdx = paddr[13:2];
   assign wrStrobe = psel && penable && pwrite;
   assign wdata = pwdata[15:0];
   assign pready = 1'b1;
   assign anyPress = |buttonPress;
   assign stepPress = buttonPress[0] | buttonPress[1];

   always_comb
   begin
      case (regIdx)
         IDX_MAINS_FREQ, IDX_CONTRAST, IDX_OP_LIGHT, IDX_SCREEN_PROF,
         IDX_ROT_PROF, IDX_ROT_TIME, IDX_MINMAX_CLR, IDX_ENERGY_CLR,
         IDX_IDLE_INTERVAL, IDX_STBY_LIGHT, IDX_STATUS, IDX_CONTROL:
            mapped = 1'b1;
         default:
            mapped = 1'b0;
      endcase
   end
   assign pslverr = psel && penable && !mapped;

   // Each parameter only loads a legal value; anything else keeps the old one.
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         mainsFreqSel <= RST_MAINS_FREQ;
         contrast <= RST_CONTRAST;
         opLight <= RST_OP_LIGHT;
         screenProfile <= RST_PROFILE;
         rotProfile <= RST_PROFILE;
         rotTime <= RST_ROT_TIME;
         idleInterval <= RST_IDLE_INTERVAL;
         stbyLight <= RST_STBY_LIGHT;
      end
      else if (wrStrobe)
      begin
         case (regIdx)
            IDX_MAINS_FREQ:
               if (wdata == 16'h0 || (wdata >= FREQ_MIN && wdata <= FREQ_MAX))
                  mainsFreqSel <= wdata;
            IDX_CONTRAST:
               if (wdata <= LEVEL_MAX)
                  contrast <= wdata;
            IDX_OP_LIGHT:
               if (wdata <= LEVEL_MAX)
                  opLight <= wdata;
            IDX_SCREEN_PROF:
               if (wdata <= PROF_MAX)
                  screenProfile <= wdata;
            IDX_ROT_PROF:
               if (wdata <= PROF_MAX)
                  rotProfile <= wdata;
            IDX_ROT_TIME:
               if (wdata <= ROT_TIME_MAX)
                  rotTime <= wdata;
            IDX_IDLE_INTERVAL:
               if (wdata >= IDLE_MIN && wdata <= IDLE_MAX)
                  idleInterval <= wdata;
            IDX_STBY_LIGHT:
               if (wdata <= LEVEL_MAX)
                  stbyLight <= wdata;
            default:
               ;
         endcase
      end
   end

   // Clear commands are one-cycle pulses to the measurement core.
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         minmaxClear <= 1'b0;
         energyClear <= 1'b0;
      end
      else
      begin
         minmaxClear <= wrStrobe && regIdx == IDX_MINMAX_CLR &&
            wdata == CLEAR_CMD;
         energyClear <= wrStrobe && regIdx == IDX_ENERGY_CLR &&
            wdata == CLEAR_CMD;
      end
   end

   assign errAck = wrStrobe && regIdx == IDX_CONTROL && pwdata[CT_ERR_ACK];

   // The frequency detector reports valid only above the 10 V threshold.
   assign freqAutoEnable = (mainsFreqSel == 16'h0) && voltagePresent;

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         lastFreq <= 16'h0;
      else if (freqAutoEnable && freqValid)
         lastFreq <= measuredFreq;
   end

   // Sampling keeps running on the last frequency rather than stopping.
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         effectiveFreq <= 16'h0;
      else if (mainsFreqSel != 16'h0)
         effectiveFreq <= mainsFreqSel;
      else
         effectiveFreq <= lastFreq;
   end

   // A new loss of frequency wins over a simultaneous acknowledge.
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         freqError <= 1'b0;
      else if (mainsFreqSel != 16'h0)
         freqError <= 1'b0;
      else if (!voltagePresent && !freqValid)
         freqError <= 1'b1;
      else if (errAck || (errHoldCnt >= ERR_HOLD_SEC))
         freqError <= 1'b0;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         errHoldCnt <= 16'h0;
      else if (!freqError || !(voltagePresent && freqValid))
         errHoldCnt <= 16'h0;
      else if (ticks.secTick)
         errHoldCnt <= errHoldCnt + 16'h1;
   end

   assign errorCode = freqError ? FREQ_ERR_CODE : 16'h0;
   assign harmonicMaxOrder = HARMONIC_ORDER;
   // Harmonic and distortion arithmetic needs a fundamental in range.
   assign calcEnable = calcStrobe &&
      effectiveFreq >= FREQ_MIN && effectiveFreq <= FREQ_MAX;
   assign screenRefresh = ticks.secTick;

   // Manual stepping holds off rotation until a minute passes with no press.
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         manualMode <= 1'b0;
         manualCnt <= 16'h0;
      end
      else if (anyPress)
      begin
         manualMode <= 1'b1;
         manualCnt <= 16'h0;
      end
      else if (manualMode && ticks.secTick)
      begin
         if (manualCnt + 16'h1 >= MANUAL_SEC)
            manualMode <= 1'b0;
         manualCnt <= manualCnt + 16'h1;
      end
   end

   assign autoRotate = !manualMode && rotTime != 16'h0;
   assign activeProfile = manualMode ? screenProfile[1:0] : rotProfile[1:0];

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         screenIndex <= '0;
         rotCnt <= 16'h0;
      end
      else if (stepPress)
      begin
         screenIndex <= screenIndex + 1'b1;
         rotCnt <= 16'h0;
      end
      else if (autoRotate && ticks.secTick)
      begin
         if (rotCnt + 16'h1 >= rotTime)
         begin
            screenIndex <= screenIndex + 1'b1;
            rotCnt <= 16'h0;
         end
         else
            rotCnt <= rotCnt + 16'h1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         rotationIndicator <= ROT_NONE;
      else if (!phaseSeqValid)
         rotationIndicator <= ROT_NONE;
      else if (phaseSeqClockwise)
         rotationIndicator <= ROT_RIGHT;
      else
         rotationIndicator <= ROT_LEFT;
   end

   // Idle timer for the backlight; any of the three buttons restarts it.
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         standby <= 1'b0;
         idleCnt <= 16'h0;
      end
      else if (anyPress)
      begin
         standby <= 1'b0;
         idleCnt <= 16'h0;
      end
      else if (!standby && ticks.secTick)
      begin
         if (idleCnt + 16'h1 >= idleInterval)
            standby <= 1'b1;
         idleCnt <= idleCnt + 16'h1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         flashPhase <= 1'b0;
      else if (!identifyRequest)
         flashPhase <= 1'b0;
      else if (ticks.flashTick)
         flashPhase <= !flashPhase;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         contrastLevel <= RST_CONTRAST[3:0];
         backlightLevel <= RST_OP_LIGHT[3:0];
      end
      else
      begin
         contrastLevel <= contrast[3:0];
         if (identifyRequest)
            backlightLevel <= flashPhase ? LIGHT_MIN : LIGHT_MAX;
         else if (standby)
            backlightLevel <= stbyLight[3:0];
         else
            backlightLevel <= opLight[3:0];
      end
   end

   // Reads return data in the access cycle; clear registers read as zero.
   always_comb
   begin
      prdata = 32'h0;
      if (psel && !pwrite)
      begin
         case (regIdx)
            IDX_MAINS_FREQ: prdata = {16'h0, mainsFreqSel};
            IDX_CONTRAST: prdata = {16'h0, contrast};
            IDX_OP_LIGHT: prdata = {16'h0, opLight};
            IDX_SCREEN_PROF: prdata = {16'h0, screenProfile};
            IDX_ROT_PROF: prdata = {16'h0, rotProfile};
            IDX_ROT_TIME: prdata = {16'h0, rotTime};
            IDX_IDLE_INTERVAL: prdata = {16'h0, idleInterval};
            IDX_STBY_LIGHT: prdata = {16'h0, stbyLight};
            IDX_STATUS:
            begin
               prdata[ST_FREQ_ERR] = freqError;
               prdata[ST_AUTO_ROT] = autoRotate;
               prdata[ST_STANDBY] = standby;
               prdata[ST_ROT_DIR_LO +: 2] = rotationIndicator;
               prdata[ST_ERR_CODE_LO +: 16] = errorCode;
            end
            default: prdata = 32'h0;
         endcase
      end
   end
endmodule

// ==== mdp_param_bank_monitor.sv ====
module mdp_param_bank_monitor
   import mdp_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [13:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [2:0] buttonPress,
   input wire logic voltagePresent,
   input wire logic phaseSeqValid,
   input wire logic phaseSeqClockwise,
   input wire logic calcStrobe,
   input wire logic minmaxClear,
   input wire logic energyClear,
   input wire logic freqAutoEnable,
   input wire logic [15:0] effectiveFreq,
   input wire logic freqError,
   input wire logic [15:0] errorCode,
   input wire logic [5:0] harmonicMaxOrder,
   input wire logic calcEnable,
   input wire logic autoRotate,
   input wire logic [1:0] rotationIndicator
);
   timeunit 1ns;
   timeprecision 100ps;
   logic clrWr, mmWr, enWr;
   assign clrWr = psel && penable && pwrite && pwdata[15:0] == CLEAR_CMD;
   assign mmWr = clrWr && paddr[13:2] == IDX_MINMAX_CLR;
   assign enWr = clrWr && paddr[13:2] == IDX_ENERGY_CLR;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   chk_minmax_pulse:
      assert property (mmWr |=> minmaxClear)
         else $error("minmax clear pulse missing");
   // A held clear would wipe the meters again on every cycle.
   chk_energy_pulse:
      assert property (enWr |=> energyClear ##1 !energyClear)
         else $error("energy clear not a single pulse");
   chk_err_code:
      assert property (errorCode == (freqError ? FREQ_ERR_CODE : 16'h0000))
         else $error("error code does not follow error flag");
   chk_auto_voltage:
      assert property (freqAutoEnable |-> voltagePresent)
         else $error("frequency detection without voltage");
   chk_harm_order:
      assert property (harmonicMaxOrder == 6'h28)
         else $error("harmonic order limit wrong");
   // Recalculation only runs on a fundamental inside the harmonic range.
   chk_calc_follow:
      assert property (calcEnable == (calcStrobe &&
         effectiveFreq >= FREQ_MIN && effectiveFreq <= FREQ_MAX))
         else $error("recalculation strobe lost");
   chk_rot_dir:
      assert property (rotationIndicator == ROT_RIGHT
         |-> $past(phaseSeqValid && phaseSeqClockwise))
         else $error("right-hand shown without clockwise sequence");
   chk_press_manual:
      assert property (|buttonPress[1:0] |=> !autoRotate)
         else $error("button press did not stop rotation");
   cover property ($rose(freqError));
   cover property (minmaxClear);
   cover property ($fell(autoRotate));
endmodule

// ==== mdp_sense_model.sv ====
module mdp_sense_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic lineOn,
   input wire logic [15:0] lineHz,
   output logic voltagePresent,
   output logic freqValid,
   output logic [15:0] measuredFreq
);
   timeunit 1ns;
   timeprecision 100ps;
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         voltagePresent <= 1'b0;
         freqValid <= 1'b0;
         measuredFreq <= 16'h0000;
      end
      else
      begin
         voltagePresent <= lineOn;
         freqValid <= lineOn;
         // A lost reading flips between the stale value and its negation every cycle.
         measuredFreq <= lineOn ? lineHz : ~measuredFreq + 16'h0001;
      end
   end
endmodule

// ==== mdp_param_bank_tb_top.sv ====
module mdp_param_bank_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import mdp_pkg::*;
   localparam int SEC = 20;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [13:0] paddr = 14'h0000;
   logic [31:0] pwdata = 32'h00000000, prdata, rdv;
   logic pready, pslverr, errv, voltagePresent, freqValid;
   logic [2:0] buttonPress = 3'h0;
   logic phaseSeqValid = 1'b0, phaseSeqClockwise = 1'b0;
   logic identifyRequest = 1'b0, calcStrobe = 1'b0, lineOn = 1'b1;
   logic [15:0] lineHz = 16'h0032, measuredFreq, effectiveFreq, errorCode;
   logic minmaxClear, energyClear, freqAutoEnable, freqError, calcEnable;
   logic screenRefresh, autoRotate;
   logic [5:0] harmonicMaxOrder;
   logic [1:0] activeProfile, rotationIndicator, e;
   logic [3:0] screenIndex, contrastLevel, backlightLevel;
   int numErrors = 0, totalChecks = 0, nMin = 0, nEng = 0, nRef = 0;
   logic [11:0] regIdx [8] = '{IDX_MAINS_FREQ, IDX_CONTRAST, IDX_OP_LIGHT,
      IDX_SCREEN_PROF, IDX_ROT_PROF, IDX_ROT_TIME, IDX_IDLE_INTERVAL,
      IDX_STBY_LIGHT};
   logic [15:0] hiVal [8] = '{FREQ_MAX, LEVEL_MAX, LEVEL_MAX, PROF_MAX,
      PROF_MAX, ROT_TIME_MAX, IDLE_MAX, LEVEL_MAX};
   logic [15:0] shadow [8] = '{RST_MAINS_FREQ, RST_CONTRAST, RST_OP_LIGHT,
      RST_PROFILE, RST_PROFILE, RST_ROT_TIME, RST_IDLE_INTERVAL,
      RST_STBY_LIGHT};
   always #4 clk = ~clk;
   mdp_param_bank #(.SEC_CYCLES(SEC)) u_dut (.clk(clk), .sys_rst(sys_rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .buttonPress(buttonPress), .voltagePresent(voltagePresent),
      .freqValid(freqValid), .measuredFreq(measuredFreq),
      .phaseSeqValid(phaseSeqValid), .phaseSeqClockwise(phaseSeqClockwise),
      .identifyRequest(identifyRequest), .calcStrobe(calcStrobe),
      .minmaxClear(minmaxClear), .energyClear(energyClear),
      .freqAutoEnable(freqAutoEnable), .effectiveFreq(effectiveFreq),
      .freqError(freqError), .errorCode(errorCode),
      .harmonicMaxOrder(harmonicMaxOrder), .calcEnable(calcEnable),
      .screenRefresh(screenRefresh), .autoRotate(autoRotate),
      .activeProfile(activeProfile), .screenIndex(screenIndex),
      .rotationIndicator(rotationIndicator), .contrastLevel(contrastLevel),
      .backlightLevel(backlightLevel));
   mdp_sense_model u_far (.clk(clk), .sys_rst(sys_rst), .lineOn(lineOn),
      .lineHz(lineHz), .voltagePresent(voltagePresent),
      .freqValid(freqValid), .measuredFreq(measuredFreq));
   always @(posedge clk)
   begin
      calcStrobe <= ($urandom % 8) == 0;
      nMin <= nMin + int'(minmaxClear === 1'b1);
      nEng <= nEng + int'(energyClear === 1'b1);
      nRef <= nRef + int'(screenRefresh === 1'b1);
   end
   function automatic logic legal(input int k, input logic [15:0] v);
      if (k == 0)
         return v == 16'h0000 || (v >= FREQ_MIN && v <= FREQ_MAX);
      if (k == 6)
         return v >= IDLE_MIN && v <= IDLE_MAX;
      return v <= hiVal[k];
   endfunction
   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      totalChecks++;
      if (seen !== exp)
      begin
         numErrors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] i,
      input logic [15:0] v);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= {16'h0000, v};
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic press(input logic [2:0] m);
      buttonPress <= m;
      @(posedge clk);
      buttonPress <= 3'h0;
      @(posedge clk);
      @(posedge clk);
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", totalChecks, numErrors);
      if (numErrors == 0 && totalChecks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk);
      numErrors++;
      report_and_stop;
   end
   initial
   begin
      int k, s9, s0, so;
      logic [15:0] v;
      void'($urandom(28668));
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      check("contrast out", contrastLevel, 4'h5);
      check("light out", backlightLevel, 4'h6);
      for (k = 0; k < 8; k++)
      begin
         apb(1'b0, regIdx[k], 16'h0000);
         check("reset value", rdv, shadow[k]);
      end
      $display("reset test done");
      // Half the draws sit on the upper limit or one past it.
      for (int n = 0; n < 60; n++)
      begin
         k = $urandom % 8;
         v = 16'($urandom % (hiVal[k] + 8));
         if ($urandom % 2)
            v = hiVal[k] + 16'($urandom % 2);
         if (legal(k, v))
            shadow[k] = v;
         apb(1'b1, regIdx[k], v);
         apb(1'b0, regIdx[k], 16'h0000);
         check("read back", rdv, shadow[k]);
         check("contrast out", contrastLevel, shadow[1][3:0]);
      end
      apb(1'b0, 12'h100, 16'h0000);
      check("unmapped err", errv, 1'b1);
      check("unmapped data", rdv, 32'h00000000);
      $display("register test done");
      apb(1'b1, IDX_MINMAX_CLR, CLEAR_CMD);
      apb(1'b1, IDX_ENERGY_CLR, 16'h0002);
      apb(1'b1, IDX_ENERGY_CLR, CLEAR_CMD);
      @(posedge clk);
      check("minmax pulses", nMin, 32'h1);
      check("energy pulses", nEng, 32'h1);
      $display("clear test done");
      apb(1'b1, IDX_MAINS_FREQ, 16'h0000);
      repeat (4) @(posedge clk);
      check("auto freq", effectiveFreq, 16'h0032);
      lineOn <= 1'b0;
      repeat (4) @(posedge clk);
      check("err flag", freqError, 1'b1);
      check("err code", errorCode, 16'h01f4);
      check("held freq", effectiveFreq, 16'h0032);
      lineHz <= 16'h003c;
      lineOn <= 1'b1;
      repeat (60) @(posedge clk);
      check("err kept", freqError, 1'b1);
      apb(1'b0, IDX_STATUS, 16'h0000);
      check("status err", {rdv[31:16], rdv[0]}, {FREQ_ERR_CODE, 1'b1});
      repeat (80) @(posedge clk);
      check("err cleared", freqError, 1'b0);
      check("new freq", effectiveFreq, 16'h003c);
      apb(1'b1, IDX_MAINS_FREQ, 16'h002d);
      lineOn <= 1'b0;
      repeat (30) @(posedge clk);
      check("fixed no err", freqError, 1'b0);
      check("fixed freq", effectiveFreq, 16'h002d);
      apb(1'b1, IDX_MAINS_FREQ, 16'h0000);
      @(posedge clk);
      check("err again", freqError, 1'b1);
      lineOn <= 1'b1;
      repeat (4) @(posedge clk);
      apb(1'b1, IDX_CONTROL, 16'h0001);
      check("err acked", freqError, 1'b0);
      $display("frequency test done");
      for (k = 0; k < 4; k++)
      begin
         phaseSeqValid <= k[1];
         phaseSeqClockwise <= k[0];
         repeat (3) @(posedge clk);
         e = !k[1] ? ROT_NONE : (k[0] ? ROT_RIGHT : ROT_LEFT);
         check("rotation dir", rotationIndicator, e);
      end
      apb(1'b1, IDX_ROT_TIME, 16'h0000);
      apb(1'b1, IDX_SCREEN_PROF, 16'h0002);
      check("no rotation", autoRotate, 1'b0);
      apb(1'b1, IDX_ROT_TIME, 16'h0005);
      apb(1'b1, IDX_OP_LIGHT, 16'h0007);
      apb(1'b1, IDX_STBY_LIGHT, 16'h0002);
      apb(1'b1, IDX_IDLE_INTERVAL, IDLE_MIN);
      press(3'h1);
      check("manual", autoRotate, 1'b0);
      check("operating", backlightLevel, 4'h7);
      v = 16'(screenIndex);
      press(3'h2);
      check("step", screenIndex, 4'(v + 16'h0001));
      so = nRef;
      repeat (1100) @(posedge clk);
      check("refresh", nRef - so, 1100 / SEC);
      check("still manual", autoRotate, 1'b0);
      check("profile", activeProfile, 2'h2);
      check("not standby", backlightLevel, 4'h7);
      repeat (200) @(posedge clk);
      check("rotating", autoRotate, 1'b1);
      check("standby", backlightLevel, 4'h2);
      press(3'h4);
      check("woken", backlightLevel, 4'h7);
      repeat (1100) @(posedge clk);
      check("timer restarted", backlightLevel, 4'h7);
      $display("display test done");
      identifyRequest <= 1'b1;
      repeat (3) @(posedge clk);
      s9 = 0;
      s0 = 0;
      so = 0;
      repeat (60)
      begin
         @(posedge clk);
         if (backlightLevel === LIGHT_MAX)
            s9++;
         else if (backlightLevel === LIGHT_MIN)
            s0++;
         else
            so++;
      end
      check("flash", {s9 > 0, s0 > 0, so == 0}, 3'h7);
      identifyRequest <= 1'b0;
      $display("identify test done");
      report_and_stop;
   end
endmodule
bind mdp_param_bank mdp_param_bank_monitor u_mon (.clk(clk),
   .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .buttonPress(buttonPress),
   .voltagePresent(voltagePresent), .phaseSeqValid(phaseSeqValid),
   .phaseSeqClockwise(phaseSeqClockwise), .calcStrobe(calcStrobe),
   .minmaxClear(minmaxClear), .energyClear(energyClear),
   .freqAutoEnable(freqAutoEnable), .effectiveFreq(effectiveFreq),
   .freqError(freqError), .errorCode(errorCode),
   .harmonicMaxOrder(harmonicMaxOrder), .calcEnable(calcEnable),
   .autoRotate(autoRotate), .rotationIndicator(rotationIndicator));
